// ===== hdl/oapc_top.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module oapc_top
  import oapc_pkg::*;
#(
  parameter longint SLEEP_CYC = OAPC_SLEEP_CYC,
  parameter longint ALERT_CYC = OAPC_ALERT_CYC,
  parameter longint TICK_CYC = OAPC_TICK_CYC,
  parameter longint MIN_CYC = OAPC_MIN_CYC,
  parameter longint DEBOUNCE_CYC = OAPC_DEBOUNCE_CYC,
  parameter longint WAKE_SHORT_CYC = OAPC_DEBOUNCE_CYC,
  parameter longint WAKE_LONG_CYC = 4 * OAPC_DEBOUNCE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire oapc_pins_t pins,
  input wire logic transmitting,
  input wire logic monitor_mode,
  output oapc_msgs_t msgs,
  output logic low_power,
  output logic force_recessive,
  output logic volt_ctrl,
  output logic power_ctrl,
  output logic warm_start,
  output logic key_level_query
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    oapc_pins_t s1;
    oapc_pins_t s2;
    logic [7:0] pwr_opt;
    logic [7:0] quiet_opt;
    logic [7:0] quiet_tmo;
    logic tmo_loaded;
    logic mon_en;
    logic [3:0] bus_flt;
    logic [23:0] poll_cnt;
    logic [31:0] tick_cnt;
    logic [7:0] quiet_cnt;
    logic [39:0] serial_cnt;
    logic warned;
    logic quiet_warned;
    logic key_filt;
    logic [31:0] key_cnt;
    logic key_low_seen;
    logic [31:0] rx_cnt;
    logic bus_armed;
    oapc_mode_t mode;
    oapc_src_t src;
    logic [31:0] dly_cnt;
    oapc_msgs_t msgs;
    logic warm;
    logic [31:0] prdata;
  } oapc_state_t;

  oapc_state_t st;
  oapc_state_t next_st;

  function automatic logic [31:0] sat_inc32(input logic [31:0] v);
    sat_inc32 = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
  endfunction : sat_inc32

  logic wr;
  logic rd;
  logic bus_active;
  logic master;
  logic [39:0] serial_lim;
  logic [7:0] quiet_lim;
  logic key_stable;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign master = st.pwr_opt[OAPC_MASTER_BIT];
  assign bus_active = |st.bus_flt;

  always_comb begin
    next_st = st;
    next_st.msgs = '0;
    next_st.warm = 1'b0;
    serial_lim = st.pwr_opt[OAPC_SERIAL_LONG_BIT] ? 40'(OAPC_LONG_MIN * MIN_CYC)
                                                  : 40'(OAPC_SHORT_MIN * MIN_CYC);
    quiet_lim = st.tmo_loaded ? st.quiet_tmo
              : (st.quiet_opt[OAPC_QUIET_LONG_BIT] ? OAPC_QUIET_LONG_TICKS : OAPC_QUIET_SHORT_TICKS);
    key_stable = (st.key_cnt >= 32'(DEBOUNCE_CYC));

    // ----------------------------------------
    // Pin synchronisers and bus filter
    // ----------------------------------------
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.poll_cnt = (st.poll_cnt >= 24'(OAPC_POLL_CYC - 1)) ? '0 : st.poll_cnt + 24'h1;
    // Sampled every cycle, far inside the poll interval; own traffic masked
    next_st.bus_flt = transmitting ? 4'h0 : (st.bus_flt & st.s2.bus_in) | (st.s2.bus_in & ~st.bus_flt & st.s1.bus_in
                                                                           & st.s2.bus_in);

    // ----------------------------------------
    // Activity monitor
    // ----------------------------------------
    if (transmitting) begin
      next_st.mon_en = 1'b1;
    end
    next_st.tick_cnt = (st.tick_cnt >= 32'(TICK_CYC - 1)) ? '0 : st.tick_cnt + 32'h1;
    if (!st.mon_en || monitor_mode) begin
      next_st.quiet_cnt = '0;
      next_st.quiet_warned = 1'b0;
    end else if (bus_active) begin
      next_st.quiet_cnt = '0;
      next_st.quiet_warned = 1'b0;
      next_st.tick_cnt = '0;
    end else if (st.tick_cnt >= 32'(TICK_CYC - 1) && st.quiet_cnt != 8'hFF) begin
      next_st.quiet_cnt = st.quiet_cnt + 8'h1;
    end

    // ----------------------------------------
    // Serial inactivity and key debounce
    // ----------------------------------------
    if (!st.s2.rx_in || st.mode != OAPC_RUN) begin
      next_st.serial_cnt = '0;
      next_st.warned = 1'b0;
    end else if (st.serial_cnt != 40'hFFFFFFFFFF) begin
      next_st.serial_cnt = st.serial_cnt + 40'h1;
    end
    next_st.key_cnt = (st.s2.key_in != st.key_filt) ? sat_inc32(st.key_cnt) : '0;
    if (key_stable) begin
      next_st.key_filt = st.s2.key_in;
      next_st.key_cnt = '0;
      if (!st.s2.key_in) begin
        next_st.key_low_seen = 1'b1;
      end
    end
    next_st.rx_cnt = st.s2.rx_in ? '0 : sat_inc32(st.rx_cnt);

    // ----------------------------------------
    // Power sequencer
    // ----------------------------------------
    unique case (st.mode)
      OAPC_RUN: begin
        next_st.dly_cnt = '0;
        if (master && st.serial_cnt == serial_lim - 40'(OAPC_WARN_MIN * MIN_CYC)
            && st.pwr_opt[OAPC_SERIAL_EN_BIT] && st.pwr_opt[OAPC_WARN_EN_BIT] && !st.warned) begin
          next_st.msgs.activity_warn_msg = 1'b1;
          next_st.warned = 1'b1;
        end
        if (st.mon_en && !monitor_mode && quiet_lim != 8'h00 && st.quiet_opt[OAPC_QUIET_EN_BIT]
            && st.quiet_opt[OAPC_QUIET_REPORT_BIT] && st.quiet_cnt == quiet_lim - 8'h1 && !st.quiet_warned
            && st.tick_cnt == '0) begin
          next_st.msgs.activity_warn_msg = 1'b1;
          next_st.quiet_warned = 1'b1;
        end
        if (master) begin
          if (wr && paddr == OAPC_CMD_ADDR && pwdata[OAPC_CMD_SLEEP]) begin
            next_st.mode = OAPC_ENTRY;
            next_st.src = OAPC_SRC_CMD;
          end else if ((st.pwr_opt[OAPC_SERIAL_EN_BIT] && st.serial_cnt >= serial_lim)
                       || (st.quiet_opt[OAPC_QUIET_EN_BIT] && st.quiet_opt[OAPC_QUIET_SLEEP_BIT]
                           && st.mon_en && !monitor_mode && quiet_lim != 8'h00 && st.quiet_cnt >= quiet_lim)
                       || (st.pwr_opt[OAPC_KEY_EN_BIT] && key_stable && !st.s2.key_in)) begin
            next_st.mode = OAPC_ENTRY;
            next_st.src = OAPC_SRC_ALERT;
            next_st.msgs.sleep_warning_msg = 1'b1;
          end
        end
      end
      OAPC_ENTRY: begin
        next_st.dly_cnt = st.dly_cnt + 32'h1;
        if (st.dly_cnt >= ((st.src == OAPC_SRC_CMD) ? 32'(SLEEP_CYC - 1) : 32'(ALERT_CYC - 1))) begin
          next_st.mode = OAPC_LOW;
          next_st.bus_armed = 1'b0;
          next_st.key_low_seen = 1'b0;
          next_st.dly_cnt = '0;
        end
      end
      OAPC_LOW: begin
        if (!bus_active) begin
          next_st.bus_armed = 1'b1;
        end
        if (st.rx_cnt >= 32'(OAPC_RX_WAKE_CYC)) begin
          next_st.mode = OAPC_WAKE;
          next_st.dly_cnt = 32'(WAKE_SHORT_CYC);
        end else if (st.bus_armed && bus_active) begin
          next_st.mode = OAPC_WAKE;
          next_st.dly_cnt = 32'(WAKE_SHORT_CYC);
        end else if (st.key_low_seen && key_stable && st.s2.key_in) begin
          next_st.mode = OAPC_WAKE;
          next_st.dly_cnt = st.pwr_opt[OAPC_WAKE_DLY_BIT] ? 32'(WAKE_LONG_CYC) : 32'(WAKE_SHORT_CYC);
        end
      end
      OAPC_WAKE: begin
        next_st.dly_cnt = st.dly_cnt - 32'h1;
        if (st.dly_cnt <= 32'h1) begin
          next_st.mode = OAPC_RUN;
          next_st.src = OAPC_SRC_NONE;
          next_st.warm = 1'b1;
          next_st.dly_cnt = '0;
        end
      end
    endcase

    // RTS use of the key input: a rise aborts bus work
    if (st.s2.rts_alt && key_stable && st.s2.key_in && !st.key_filt && st.mode == OAPC_RUN) begin
      next_st.msgs.stopped_msg = 1'b1;
    end

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    if (wr) begin
      unique case (paddr)
        OAPC_PWR_OPT_ADDR: next_st.pwr_opt = pwdata[7:0];
        OAPC_QUIET_OPT_ADDR: next_st.quiet_opt = pwdata[7:0];
        OAPC_QUIET_TMO_ADDR: begin
          next_st.quiet_tmo = pwdata[7:0];
          next_st.tmo_loaded = 1'b1;
        end
        OAPC_CMD_ADDR: begin
          if (pwdata[OAPC_CMD_SERIAL_ACT]) begin
            next_st.serial_cnt = '0;
            next_st.warned = 1'b0;
          end
          if (pwdata[OAPC_CMD_FIRST_TX]) begin
            next_st.mon_en = 1'b1;
          end
          if (pwdata[OAPC_CMD_TMO_DEFAULT]) begin
            next_st.tmo_loaded = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    next_st.prdata = '0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OAPC_PWR_OPT_ADDR: next_st.prdata = {24'h0, st.pwr_opt};
        OAPC_QUIET_OPT_ADDR: next_st.prdata = {24'h0, st.quiet_opt};
        OAPC_QUIET_TMO_ADDR: next_st.prdata = {24'h0, quiet_lim};
        OAPC_STATUS_ADDR: next_st.prdata = {26'h0, st.mon_en, st.tmo_loaded, st.mode, st.s2.key_in, st.mode == OAPC_LOW};
        OAPC_QUIET_CNT_ADDR: next_st.prdata = {24'h0, st.quiet_cnt};
        default: next_st.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.s1 <= '{bus_in: 4'h0, key_in: 1'b1, rx_in: 1'b1, rts_alt: 1'b0};
      st.s2 <= '{bus_in: 4'h0, key_in: 1'b1, rx_in: 1'b1, rts_alt: 1'b0};
      st.key_filt <= 1'b1;
      st.pwr_opt <= OAPC_PWR_OPT_RST;
      st.quiet_opt <= OAPC_QUIET_OPT_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = st.prdata;
  assign pslverr = 1'b0;
  assign msgs = st.msgs;
  assign low_power = (st.mode == OAPC_LOW);
  assign force_recessive = (st.mode == OAPC_LOW);
  assign volt_ctrl = 1'b0;
  assign power_ctrl = (st.mode == OAPC_LOW);
  assign warm_start = st.warm;
  assign key_level_query = st.s2.key_in;

endmodule : oapc_top

`default_nettype wire

// ===== hdl/oapc_pkg.sv
package oapc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OAPC_PWR_OPT_ADDR = 8'h00;
  localparam logic [7:0] OAPC_QUIET_OPT_ADDR = 8'h04;
  localparam logic [7:0] OAPC_QUIET_TMO_ADDR = 8'h08;
  localparam logic [7:0] OAPC_CMD_ADDR = 8'h0C;
  localparam logic [7:0] OAPC_STATUS_ADDR = 8'h10;
  localparam logic [7:0] OAPC_QUIET_CNT_ADDR = 8'h14;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] OAPC_PWR_OPT_RST = 8'h9A;
  localparam logic [7:0] OAPC_QUIET_OPT_RST = 8'hD5;
  localparam int OAPC_MASTER_BIT = 7;
  localparam int OAPC_SERIAL_EN_BIT = 5;
  localparam int OAPC_SERIAL_LONG_BIT = 4;
  localparam int OAPC_WARN_EN_BIT = 3;
  localparam int OAPC_KEY_EN_BIT = 2;
  localparam int OAPC_WAKE_DLY_BIT = 1;
  localparam int OAPC_QUIET_EN_BIT = 7;
  localparam int OAPC_QUIET_SLEEP_BIT = 5;
  localparam int OAPC_QUIET_LONG_BIT = 4;
  localparam int OAPC_QUIET_REPORT_BIT = 3;
  // Command register bits
  localparam int OAPC_CMD_SLEEP = 0;
  localparam int OAPC_CMD_SERIAL_ACT = 1;
  localparam int OAPC_CMD_FIRST_TX = 2;
  localparam int OAPC_CMD_CLR_EVT = 3;
  localparam int OAPC_CMD_TMO_DEFAULT = 4;

  // ----------------------------------------
  // Timing (figures as printed, then cycles at 250 MHz)
  // ----------------------------------------
  localparam longint OAPC_CLK_HZ = 250000000;
  localparam longint OAPC_POLL_US = 4000;
  localparam longint OAPC_TICK_NS = 655360000;
  localparam longint OAPC_SLEEP_DLY_MS = 1000;
  localparam longint OAPC_ALERT_DLY_MS = 2000;
  localparam longint OAPC_RX_WAKE_US = 128;
  localparam longint OAPC_SHORT_MIN = 5;
  localparam longint OAPC_LONG_MIN = 20;
  localparam longint OAPC_WARN_MIN = 1;
  localparam longint OAPC_POLL_CYC = OAPC_POLL_US * OAPC_CLK_HZ / 1000000;
  localparam longint OAPC_TICK_CYC = OAPC_TICK_NS * OAPC_CLK_HZ / 1000000000;
  localparam longint OAPC_SLEEP_CYC = OAPC_SLEEP_DLY_MS * OAPC_CLK_HZ / 1000;
  localparam longint OAPC_ALERT_CYC = OAPC_ALERT_DLY_MS * OAPC_CLK_HZ / 1000;
  localparam longint OAPC_RX_WAKE_CYC = (OAPC_RX_WAKE_US * OAPC_CLK_HZ + 999999) / 1000000;
  localparam longint OAPC_MIN_CYC = 60 * OAPC_CLK_HZ;
  localparam longint OAPC_DEBOUNCE_CYC = 1000000;
  // Quiet default timeouts, in idle ticks
  localparam logic [7:0] OAPC_QUIET_SHORT_TICKS = 8'h1C;
  localparam logic [7:0] OAPC_QUIET_LONG_TICKS = 8'h6E;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    OAPC_RUN = 2'b00,
    OAPC_ENTRY = 2'b01,
    OAPC_LOW = 2'b10,
    OAPC_WAKE = 2'b11
  } oapc_mode_t;

  typedef enum logic [1:0] {
    OAPC_SRC_NONE = 2'b00,
    OAPC_SRC_CMD = 2'b01,
    OAPC_SRC_ALERT = 2'b10
  } oapc_src_t;

  typedef struct packed {
    logic [3:0] bus_in;
    logic key_in;
    logic rx_in;
    logic rts_alt;
  } oapc_pins_t;

  typedef struct packed {
    logic sleep_warning_msg;
    logic activity_warn_msg;
    logic stopped_msg;
  } oapc_msgs_t;

endpackage : oapc_pkg

// ===== bench/oapc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module oapc_top_sva
  import oapc_pkg::*;
#(
  parameter longint ALERT_CYC = OAPC_ALERT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire oapc_pins_t pins,
  input wire oapc_msgs_t msgs,
  input wire logic low_power,
  input wire logic force_recessive,
  input wire logic volt_ctrl,
  input wire logic power_ctrl,
  input wire logic warm_start,
  input wire logic key_level_query
);
  // Slack of three cycles covers the registered warning pulse
  localparam int AL = int'(ALERT_CYC) - 3;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_volt_low: assert property (volt_ctrl == 1'b0)
    else $error("voltage control not low");
  a_lp_outputs: assert property (force_recessive == low_power && power_ctrl == low_power)
    else $error("low power outputs disagree");
  a_cnt_byte: assert property (psel && penable && !pwrite && paddr == OAPC_QUIET_CNT_ADDR |-> prdata[31:8] == 24'h0)
    else $error("quiet count wider than a byte");
  a_key_query: assert property ($stable(pins.key_in) [*5] |-> key_level_query == pins.key_in)
    else $error("key level query stale");
  a_warn_delay: assert property (msgs.sleep_warning_msg |-> ##AL !low_power ##[1:6] low_power)
    else $error("low power not two seconds after warning");
  a_act_warn: assert property (msgs.activity_warn_msg |-> !low_power ##1 !msgs.activity_warn_msg)
    else $error("activity warning malformed");
  a_wake_done: assert property ($rose(warm_start) |-> !low_power ##1 !warm_start)
    else $error("warm start pulse malformed");
  a_ready_now: assert property (psel && penable |-> pready && !pslverr)
    else $error("bus answer late or in error");
endmodule : oapc_top_sva
bind oapc_top oapc_top_sva #(.ALERT_CYC(ALERT_CYC)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .msgs(msgs), .low_power(low_power), .force_recessive(force_recessive), .volt_ctrl(volt_ctrl),
  .power_ctrl(power_ctrl), .warm_start(warm_start), .key_level_query(key_level_query));
`default_nettype wire

// ===== bench/oapc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module oapc_host_model
  import oapc_pkg::*;
#(
  parameter int LOW_CYC = int'(OAPC_RX_WAKE_CYC) + 100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake_req,
  output logic rx_out
);
  int cnt;
  // Line idles high; a wake request holds it low past the minimum width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else if (wake_req && cnt == 0) cnt <= LOW_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign rx_out = (cnt == 0);
endmodule : oapc_host_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import oapc_pkg::*;
  localparam int SLP = 40;
  localparam int ALR = 30;
  localparam int TCK = 20;
  localparam int MNC = 50;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic transmitting = 0, monitor_mode = 0, key = 1, wake_req = 0, rts = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [3:0] bus = 4'h0;
  wire logic rx;
  oapc_pins_t pins;
  oapc_msgs_t msgs;
  logic pready, pslverr, low_power, force_recessive, volt_ctrl, power_ctrl, warm_start, key_level_query;
  int error_cnt = 0, cmp_count = 0, sw_cnt = 0, wm_cnt = 0, st_cnt = 0, n, m;
  assign pins = '{bus_in: bus, key_in: key, rx_in: rx, rts_alt: rts};
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    if (msgs.sleep_warning_msg === 1'b1) sw_cnt++;
    if (warm_start === 1'b1) wm_cnt++;
    if (msgs.stopped_msg === 1'b1) st_cnt++;
  end
  oapc_host_model u_host (.pclk(pclk), .presetn(presetn), .wake_req(wake_req), .rx_out(rx));
  oapc_top #(.SLEEP_CYC(SLP), .ALERT_CYC(ALR), .TICK_CYC(TCK), .MIN_CYC(MNC), .DEBOUNCE_CYC(8),
    .WAKE_SHORT_CYC(8), .WAKE_LONG_CYC(16)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .transmitting(transmitting), .monitor_mode(monitor_mode), .msgs(msgs),
    .low_power(low_power), .force_recessive(force_recessive), .volt_ctrl(volt_ctrl), .power_ctrl(power_ctrl),
    .warm_start(warm_start), .key_level_query(key_level_query));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task finish_test;
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 100) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  // Waits for low power (0), full power (1), sleep warning (2), activity warning (3)
  task wt(input int c, input int lim, output int cnt);
    logic h;
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge pclk);
      case (c)
        0: h = (low_power === 1'b1);
        1: h = (low_power === 1'b0);
        2: h = (msgs.sleep_warning_msg === 1'b1);
        default: h = (msgs.activity_warn_msg === 1'b1);
      endcase
      if (h) return;
    end
    error_cnt++;
    finish_test();
  endtask : wt
  task key_wake;
    m = wm_cnt;
    key <= 0;
    repeat (20) @(posedge pclk);
    chk(key_level_query, 0);
    key <= 1;
    wt(1, 2000, n);
    // Full power returns at the start of the wake delay; warm start comes at its end
    repeat (24) @(posedge pclk);
    chk(wm_cnt, m + 1);
  endtask : key_wake
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    xfer(0, OAPC_PWR_OPT_ADDR, 0);
    chk(rd, {24'h0, OAPC_PWR_OPT_RST});
    xfer(0, OAPC_QUIET_OPT_ADDR, 0);
    chk(rd, {24'h0, OAPC_QUIET_OPT_RST});
    xfer(1, 8'h18, 32'h0000_00FF);
    xfer(0, 8'h18, 0);
    chk(rd, 0);
    xfer(1, OAPC_PWR_OPT_ADDR, 32'h1A);
    xfer(1, OAPC_CMD_ADDR, 32'h1);
    repeat (SLP + 20) @(posedge pclk);
    chk(low_power, 0);
    xfer(1, OAPC_PWR_OPT_ADDR, 32'h9A);
    xfer(1, OAPC_CMD_ADDR, 32'h1);
    wt(0, SLP + 20, n);
    chk(n >= SLP - 4 && n <= SLP + 2, 1);
    chk({force_recessive, power_ctrl, volt_ctrl}, 3'b110);
    key_wake();
    xfer(1, OAPC_PWR_OPT_ADDR, 32'h9E);
    key <= 0;
    wt(2, 200, n);
    wt(0, ALR + 10, n);
    chk(n >= ALR - 4, 1);
    wake_req <= 1;
    @(posedge pclk);
    wake_req <= 0;
    wt(1, 34000, n);
    key <= 1;
    xfer(1, OAPC_PWR_OPT_ADDR, 32'h9A);
    // Monitor is enabled by the first-transmit command bit, then left quiet to saturate
    xfer(1, OAPC_CMD_ADDR, 32'h4);
    repeat (6000) @(posedge pclk);
    xfer(0, OAPC_QUIET_CNT_ADDR, 0);
    chk(rd, 32'hFF);
    bus <= 4'h1;
    repeat (200) @(posedge pclk);
    xfer(0, OAPC_QUIET_CNT_ADDR, 0);
    chk(rd, 0);
    bus <= 4'h0;
    repeat (TCK * 5 + 2) @(posedge pclk);
    xfer(0, OAPC_QUIET_CNT_ADDR, 0);
    chk(rd >= 3 && rd <= 5, 1);
    xfer(1, OAPC_QUIET_OPT_ADDR, 32'hF5);
    xfer(1, OAPC_QUIET_TMO_ADDR, 32'h0);
    m = sw_cnt;
    repeat (6000) @(posedge pclk);
    chk(low_power, 0);
    chk(sw_cnt, m);
    monitor_mode <= 1;
    xfer(1, OAPC_QUIET_TMO_ADDR, 32'h3);
    repeat (500) @(posedge pclk);
    chk(low_power, 0);
    monitor_mode <= 0;
    wt(2, 2000, n);
    wt(0, ALR + 10, n);
    xfer(0, OAPC_QUIET_TMO_ADDR, 0);
    chk(rd, 32'h3);
    bus <= 4'h1;
    wt(1, 5000, n);
    bus <= 4'h0;
    xfer(1, OAPC_QUIET_OPT_ADDR, 32'hD5);
    xfer(1, OAPC_CMD_ADDR, 32'h10);
    xfer(0, OAPC_QUIET_TMO_ADDR, 0);
    chk(rd, {24'h0, OAPC_QUIET_LONG_TICKS});
    xfer(1, OAPC_PWR_OPT_ADDR, 32'hA8);
    xfer(1, OAPC_CMD_ADDR, 32'h2);
    wt(3, 400, n);
    chk(n >= 4 * MNC - 10 && n <= 4 * MNC + 10, 1);
    wt(2, MNC + 20, n);
    chk(n >= MNC - 10, 1);
    wt(0, ALR + 10, n);
    key_wake();
    xfer(1, OAPC_PWR_OPT_ADDR, 32'h9A);
    rts <= 1;
    key <= 0;
    repeat (20) @(posedge pclk);
    key <= 1;
    repeat (20) @(posedge pclk);
    chk(st_cnt, 1);
    chk(low_power, 0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
